/* common/tsac_pkg.sv */
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package tsac_pkg;

   //------------------------------------------------------------
   // Register offsets, pointer values as printed
   //------------------------------------------------------------
   localparam logic [2:0] ADDR_TEMP = 3'h0;
   localparam logic [2:0] ADDR_CFG = 3'h1;
   localparam logic [2:0] ADDR_UPPER = 3'h2;
   localparam logic [2:0] ADDR_LOWER = 3'h3;
   localparam logic [2:0] ADDR_PTR = 3'h4;
   localparam logic [2:0] ADDR_PTRDATA = 3'h5;

   // Reset values
   localparam logic [7:0] CFG_RST = 8'h40;
   localparam logic [7:0] UPPER_RST = 8'h7f;
   localparam logic [7:0] LOWER_RST = 8'h80;
   localparam logic [1:0] PTR_RST = 2'h0;

   // Serial bus constants
   localparam logic [6:0] ARA_ADDR = 7'h0c;
   localparam logic [6:0] SLAVE_ADDR = 7'h48;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   //------------------------------------------------------------
   // Timing
   //------------------------------------------------------------
   localparam int CLK_NS = 50;
   localparam int PERIOD_MS = 800;
   localparam int WAKE_NS = 4000;
   localparam int CONV_NS = 25000;
   localparam int PERIOD_CYC = PERIOD_MS * 1000000 / CLK_NS;
   localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
   localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;

   // Configuration byte, D7 down to D0
   typedef struct packed {
      logic sleep;
      logic bit6;
      logic alertOff;
      logic polHigh;
      logic alertClr;
      logic oneShot;
      logic [1:0] spare;
   } tsac_cfg_s;

   // Open-drain pin drive
   typedef struct packed {
      logic out;
      logic oe;
   } tsac_od_s;

   typedef enum logic [2:0] {
      CV_IDLE = 3'b001,
      CV_WAKE = 3'b010,
      CV_BUSY = 3'b100
   } tsac_conv_e;

   typedef enum logic [4:0] {
      AR_IDLE = 5'b00001,
      AR_ADDR = 5'b00010,
      AR_ACK = 5'b00100,
      AR_DATA = 5'b01000,
      AR_WAIT = 5'b10000
   } tsac_ara_e;

endpackage

/* hdl/tsac_core.sv */
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module tsac_core #(
   parameter int PeriodCyc = tsac_pkg::PERIOD_CYC,
   parameter int WakeCyc = tsac_pkg::WAKE_CYC,
   parameter int ConvCyc = tsac_pkg::CONV_CYC,
   parameter logic [6:0] SlaveAddr = tsac_pkg::SLAVE_ADDR
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Register port
   input wire logic [2:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [15:0] regRdData,
   // Two-wire link
   input wire logic sclIn,
   input wire logic sdaIn,
   output tsac_pkg::tsac_od_s sdaPin,
   // Alert pin
   output tsac_pkg::tsac_od_s alertPin,
   // Converter front end
   input wire logic [9:0] sensorCode,
   output logic convBusy,
   output logic powerDown
);

   //---------------------------------------------------------------
   // Declarations
   //---------------------------------------------------------------
   localparam int CntW = $clog2(ConvCyc + WakeCyc + 1);
   localparam int PerW = $clog2(PeriodCyc + 1);
   localparam int WakeMax = WakeCyc;

   tsac_pkg::tsac_cfg_s cfg, newCfg;
   logic [7:0] upper, lower;
   logic [1:0] ptr;
   logic [9:0] tempResult;
   logic upFlag, lowFlag, alertFlag, alertState, newResult;
   tsac_pkg::tsac_conv_e convState, next_conv;
   logic [CntW-1:0] cnt, next_cnt;
   logic [PerW-1:0] periodCnt;
   logic sclS1, sclS2, sclD, sdaS1, sdaS2, sdaD;
   logic busActive;
   tsac_pkg::tsac_ara_e araState, next_ara;
   logic [3:0] araBits, next_bits;
   logic [7:0] araShift, next_shift;
   logic next_drv;

   //---------------------------------------------------------------
   // Register decode
   //---------------------------------------------------------------
   // Pointer window reaches whichever register the pointer selects
   wire logic [2:0] effAddr = (regAddr == tsac_pkg::ADDR_PTRDATA) ?
      {1'b0, ptr} : regAddr;
   wire logic wrCfg = regWr && effAddr == tsac_pkg::ADDR_CFG;
   wire logic wrUpper = regWr && effAddr == tsac_pkg::ADDR_UPPER;
   wire logic wrLower = regWr && effAddr == tsac_pkg::ADDR_LOWER;
   wire logic wrPtr = regWr && regAddr == tsac_pkg::ADDR_PTR;
   wire logic tempRd = regRd && effAddr == tsac_pkg::ADDR_TEMP;
   assign newCfg = tsac_pkg::tsac_cfg_s'(regWrData);
   wire logic oneShotWr = wrCfg && newCfg.oneShot;
   wire logic sleepWr = wrCfg && newCfg.sleep && !newCfg.oneShot;

   // Result word: ten result bits, three flags, zero pad
   wire logic [15:0] tempWord = {tempResult, alertFlag, upFlag,
      lowFlag, 3'h0};
   // Reads stay live in power-down: nothing here is gated by sleep
   wire logic [15:0] rdMux =
      (effAddr == tsac_pkg::ADDR_TEMP) ? tempWord :
      (effAddr == tsac_pkg::ADDR_CFG) ? {8'h00, cfg} :
      (effAddr == tsac_pkg::ADDR_UPPER) ? {8'h00, upper} :
      (effAddr == tsac_pkg::ADDR_LOWER) ? {8'h00, lower} :
      (regAddr == tsac_pkg::ADDR_PTR) ? {14'h0000, ptr} :
      16'h0000;

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         regRdData <= 16'h0000;
      end else begin
         regRdData <= regRd ? rdMux : 16'h0000;
      end
   end

   //---------------------------------------------------------------
   // Writable registers
   //---------------------------------------------------------------
   // Clear and one-shot bits act on the write and are never stored
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cfg <= tsac_pkg::tsac_cfg_s'(tsac_pkg::CFG_RST);
         upper <= tsac_pkg::UPPER_RST;
         lower <= tsac_pkg::LOWER_RST;
         ptr <= tsac_pkg::PTR_RST;
      end else begin
         if (wrCfg) begin
            cfg <= {newCfg[7:4], 2'b00, newCfg.spare};
         end
         if (wrUpper) begin
            upper <= regWrData;
         end
         if (wrLower) begin
            lower <= regWrData;
         end
         if (wrPtr) begin
            ptr <= regWrData[1:0];
         end
      end
   end

   //---------------------------------------------------------------
   // Link input synchronisers and frame tracking
   //---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sclS1 <= 1'b1;
         sclS2 <= 1'b1;
         sclD <= 1'b1;
         sdaS1 <= 1'b1;
         sdaS2 <= 1'b1;
         sdaD <= 1'b1;
      end else begin
         sclS1 <= sclIn;
         sclS2 <= sclS1;
         sclD <= sclS2;
         sdaS1 <= sdaIn;
         sdaS2 <= sdaS1;
         sdaD <= sdaS2;
      end
   end

   wire logic sclRise = sclS2 && !sclD;
   wire logic sclFall = !sclS2 && sclD;
   wire logic startCond = !sdaS2 && sdaD && sclS2 && sclD;
   wire logic stopCond = sdaS2 && !sdaD && sclS2 && sclD;

   // A frame runs from start to stop; repeated starts keep it open
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         busActive <= 1'b0;
      end else begin
         busActive <= startCond || (busActive && !stopCond);
      end
   end

   //---------------------------------------------------------------
   // Conversion scheduler
   //---------------------------------------------------------------
   wire logic periodTick = periodCnt == PerW'(PeriodCyc - 1);
   wire logic convEnd = convState == tsac_pkg::CV_BUSY &&
      cnt == CntW'(ConvCyc - 1) && !sleepWr;
   // Strobes count as access too: a word read mid-load could tear
   wire logic accessNow = busActive || regRd || regWr;
   wire logic update = convEnd && !accessNow;

   // Next state of the wake and busy sequencer
   always_comb begin
      next_conv = convState;
      next_cnt = cnt;
      case (convState)
         tsac_pkg::CV_IDLE: begin
            if (oneShotWr && newCfg.sleep) begin
               next_conv = tsac_pkg::CV_WAKE;
               next_cnt = '0;
            end else if (oneShotWr) begin
               next_conv = tsac_pkg::CV_BUSY;
               next_cnt = '0;
            end else if (!cfg.sleep && !sleepWr && periodTick) begin
               next_conv = tsac_pkg::CV_BUSY;
               next_cnt = '0;
            end
         end
         tsac_pkg::CV_WAKE: begin
            if (cnt == CntW'(WakeCyc - 1)) begin
               next_conv = tsac_pkg::CV_BUSY;
               next_cnt = '0;
            end else begin
               next_cnt = cnt + 1'b1;
            end
         end
         tsac_pkg::CV_BUSY: begin
            if (sleepWr) begin
               next_conv = tsac_pkg::CV_IDLE;
               next_cnt = '0;
            end else if (cnt == CntW'(ConvCyc - 1)) begin
               next_conv = tsac_pkg::CV_IDLE;
               next_cnt = '0;
            end else begin
               next_cnt = cnt + 1'b1;
            end
         end
         default: begin
            next_conv = tsac_pkg::CV_IDLE;
            next_cnt = '0;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         convState <= tsac_pkg::CV_IDLE;
         cnt <= '0;
      end else begin
         convState <= next_conv;
         cnt <= next_cnt;
      end
   end

   // Period restarts on a one-shot, held at zero while asleep
   always_ff @(posedge mclk) begin
      if (sys_rst || cfg.sleep || oneShotWr || periodTick) begin
         periodCnt <= '0;
      end else begin
         periodCnt <= periodCnt + 1'b1;
      end
   end

   // Status pins for the analog side
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         convBusy <= 1'b0;
         powerDown <= 1'b0;
      end else begin
         convBusy <= convState != tsac_pkg::CV_IDLE;
         powerDown <= cfg.sleep && convState == tsac_pkg::CV_IDLE;
      end
   end

   //---------------------------------------------------------------
   // Result, flags and alert
   //---------------------------------------------------------------
   wire logic [7:0] tWhole = tempResult[9:2];
   wire logic overUpper = $signed(tWhole) > $signed(upper);
   wire logic underLower = $signed(tWhole) < $signed(lower);
   wire logic alertSet = newResult && overUpper;
   wire logic alertClr = (wrCfg && newCfg.alertClr) ||
      (newResult && underLower);
   wire logic asserted = alertState && !cfg.alertOff;
   wire logic pulling = alertPin.oe && !cfg.polHigh;

   // Flags: a condition still true on the clearing read wins
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         tempResult <= 10'h000;
         newResult <= 1'b0;
         upFlag <= 1'b0;
         lowFlag <= 1'b0;
         alertFlag <= 1'b0;
         alertState <= 1'b0;
      end else begin
         if (update) begin
            tempResult <= sensorCode;
         end
         newResult <= update;
         upFlag <= overUpper || (upFlag && !tempRd);
         lowFlag <= underLower || (lowFlag && !tempRd);
         alertFlag <= alertState || (alertFlag && !tempRd);
         alertState <= alertSet || (alertState && !alertClr);
      end
   end

   // Pin pulls low when asserted low, or when idle in high polarity
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         alertPin <= '0;
      end else begin
         alertPin.out <= 1'b0;
         alertPin.oe <= asserted ^ cfg.polHigh;
      end
   end

   //---------------------------------------------------------------
   // Alert response address responder
   //---------------------------------------------------------------
   always_comb begin
      next_ara = araState;
      next_bits = araBits;
      next_shift = araShift;
      next_drv = sdaPin.oe;
      if (stopCond) begin
         next_ara = tsac_pkg::AR_IDLE;
         next_drv = 1'b0;
      end else if (startCond) begin
         next_ara = tsac_pkg::AR_ADDR;
         next_bits = 4'h0;
         next_drv = 1'b0;
      end else begin
         case (araState)
            tsac_pkg::AR_ADDR: begin
               if (sclRise) begin
                  next_shift = {araShift[6:0], sdaS2};
                  next_bits = araBits + 1'b1;
               end else if (sclFall &&
                            araBits == tsac_pkg::BITS_PER_BYTE) begin
                  if (araShift == {tsac_pkg::ARA_ADDR, 1'b1} &&
                      pulling) begin
                     next_ara = tsac_pkg::AR_ACK;
                     next_drv = 1'b1;
                  end else begin
                     next_ara = tsac_pkg::AR_WAIT;
                  end
               end
            end
            tsac_pkg::AR_ACK: begin
               if (sclFall) begin
                  next_ara = tsac_pkg::AR_DATA;
                  next_shift = {SlaveAddr, 1'b1};
                  next_bits = 4'h0;
                  next_drv = !SlaveAddr[6];
               end
            end
            tsac_pkg::AR_DATA: begin
               if (sclRise) begin
                  next_bits = araBits + 1'b1;
                  // Released a one but line is low: a lower address won
                  if (!sdaPin.oe && !sdaS2) begin
                     next_ara = tsac_pkg::AR_WAIT;
                  end
               end else if (sclFall) begin
                  if (araBits == tsac_pkg::BITS_PER_BYTE) begin
                     next_ara = tsac_pkg::AR_WAIT;
                     next_drv = 1'b0;
                  end else begin
                     next_shift = {araShift[6:0], 1'b0};
                     next_drv = !araShift[6];
                  end
               end
            end
            default: begin
               next_drv = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         araState <= tsac_pkg::AR_IDLE;
         araBits <= 4'h0;
         araShift <= 8'h00;
         sdaPin <= '0;
      end else begin
         araState <= next_ara;
         araBits <= next_bits;
         araShift <= next_shift;
         sdaPin.out <= 1'b0;
         sdaPin.oe <= next_drv;
      end
   end

   //---------------------------------------------------------------
   // Checks
   //---------------------------------------------------------------
   property p_rst_vals;
      @(posedge mclk) disable iff (sys_rst)
      $fell(sys_rst) |-> upper == tsac_pkg::UPPER_RST &&
         lower == tsac_pkg::LOWER_RST && ptr == tsac_pkg::PTR_RST &&
         cfg == tsac_pkg::CFG_RST;
   endproperty
   a_rst_vals: assert property (p_rst_vals)
      else $error("register defaults wrong after reset");

   property p_pol;
      @(posedge mclk) disable iff (sys_rst)
      alertState && !cfg.alertOff && !cfg.polHigh ##1
         $stable(cfg) |-> alertPin.oe;
   endproperty
   a_pol: assert property (p_pol)
      else $error("active-low alert not pulling");

   property p_off;
      @(posedge mclk) disable iff (sys_rst)
      cfg.alertOff ##1 $stable(cfg) |-> alertPin.oe == cfg.polHigh;
   endproperty
   a_off: assert property (p_off)
      else $error("disabled alert still asserted");

   property p_od;
      @(posedge mclk) disable iff (sys_rst)
      !alertPin.out && !sdaPin.out;
   endproperty
   a_od: assert property (p_od)
      else $error("open-drain pin driven high");

   property p_ack;
      @(posedge mclk) disable iff (sys_rst)
      $rose(sdaPin.oe) && araState == tsac_pkg::AR_ACK |->
         $past(alertPin.oe) && !$past(cfg.polHigh);
   endproperty
   a_ack: assert property (p_ack)
      else $error("alert response acked without alert");

   property p_arb;
      @(posedge mclk) disable iff (sys_rst)
      araState == tsac_pkg::AR_DATA && sclRise && !sdaPin.oe &&
         !sdaS2 && !stopCond && !startCond |=>
         araState == tsac_pkg::AR_WAIT ##1 !sdaPin.oe;
   endproperty
   a_arb: assert property (p_arb)
      else $error("lost arbitration but kept driving");

   property p_set;
      @(posedge mclk) disable iff (sys_rst)
      newResult && overUpper |=> alertState;
   endproperty
   a_set: assert property (p_set)
      else $error("alert not set above upper limit");

   property p_clr;
      @(posedge mclk) disable iff (sys_rst)
      wrCfg && newCfg.alertClr && !alertSet |=> !alertState;
   endproperty
   a_clr: assert property (p_clr)
      else $error("alert not cleared by config write");

   property p_auto;
      @(posedge mclk) disable iff (sys_rst)
      convState == tsac_pkg::CV_IDLE && periodTick && !cfg.sleep &&
         !sleepWr && !(oneShotWr && newCfg.sleep) |=>
         convState == tsac_pkg::CV_BUSY;
   endproperty
   a_auto: assert property (p_auto)
      else $error("scheduled conversion did not start");

   property p_one;
      @(posedge mclk) disable iff (sys_rst)
      oneShotWr && !newCfg.sleep && convState == tsac_pkg::CV_IDLE
         |=> convState == tsac_pkg::CV_BUSY && periodCnt == '0;
   endproperty
   a_one: assert property (p_one)
      else $error("one-shot did not start or restart period");

   property p_load;
      @(posedge mclk) disable iff (sys_rst)
      convEnd && !accessNow |=> tempResult == $past(sensorCode);
   endproperty
   a_load: assert property (p_load)
      else $error("finished result not loaded");

   property p_hold;
      @(posedge mclk) disable iff (sys_rst)
      convEnd && accessNow |=> $stable(tempResult);
   endproperty
   a_hold: assert property (p_hold)
      else $error("result loaded during access");

   property p_sleep;
      @(posedge mclk) disable iff (sys_rst)
      sleepWr ##1 !oneShotWr |-> convState == tsac_pkg::CV_IDLE ##1
         powerDown;
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("power-down not entered");

   property p_wake;
      @(posedge mclk) disable iff (sys_rst)
      oneShotWr && newCfg.sleep && convState == tsac_pkg::CV_IDLE |=>
         convState == tsac_pkg::CV_WAKE ##[WakeMax:WakeMax]
         convState == tsac_pkg::CV_BUSY;
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake interval wrong");

   property p_stay;
      @(posedge mclk) disable iff (sys_rst)
      convState == tsac_pkg::CV_IDLE && cfg.sleep && !oneShotWr |=>
         convState == tsac_pkg::CV_IDLE;
   endproperty
   a_stay: assert property (p_stay)
      else $error("woke without one-shot");

   property p_flag;
      @(posedge mclk) disable iff (sys_rst)
      tempRd && !overUpper ##1 !overUpper |-> !upFlag;
   endproperty
   a_flag: assert property (p_flag)
      else $error("flag not cleared by result read");

   property p_resp;
      @(posedge mclk) disable iff (sys_rst)
      araState == tsac_pkg::AR_ACK && sclFall && !stopCond &&
         !startCond |=> araShift == {SlaveAddr, 1'b1};
   endproperty
   a_resp: assert property (p_resp)
      else $error("response byte is not own address");

endmodule

/* sim/tsac_host.sv */
`timescale 1ns/1ps
module tsac_host (
   // Link wires
   output logic scl,
   output logic sdaLow,
   input wire logic sda
);
   // Both lines released, clock stands still between frames
   initial begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end
   // One 400 ns bit: data moves mid-low, sampled mid-high
   task automatic bitSlot(input logic b, output logic s);
      #100 sdaLow = ~b;
      #100 scl = 1'b1;
      #100 s = sda;
      #100 scl = 1'b0;
   endtask
   // Alert response read: address, ack, one byte, no ack, stop
   // Rival stands for a second responder: its zero bits pull the line
   task automatic araRead(input logic [7:0] rival, output logic ack,
      output logic [7:0] d);
      logic s;
      logic [7:0] a;
      a = {tsac_pkg::ARA_ADDR, 1'b1};
      // Offset keeps link edges clear of the sampling clock edge
      #10 sdaLow = 1'b1;
      #200 scl = 1'b0;
      for (int i = 7; i >= 0; i--) bitSlot(a[i], s);
      bitSlot(1'b1, s);
      ack = ~s;
      for (int i = 7; i >= 0; i--) bitSlot(rival[i], d[i]);
      bitSlot(1'b1, s);
      #100 sdaLow = 1'b1;
      #100 scl = 1'b1;
      #200 sdaLow = 1'b0;
      #200;
   endtask
endmodule

/* sim/tsac_core_bench.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errCount++; \
   $display("unexpected %s exp %h got %h", nm, e, g); end end
module tsac_core_bench;
   // Short counts keep the run brief
   localparam int Per = 2000;
   localparam int Wake = 20;
   localparam int Conv = 30;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [2:0] regAddr = 3'h0;
   logic [7:0] regWrData = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [9:0] sensorCode = 10'h000;
   logic [15:0] regRdData, d;
   logic scl, hostLow, sdaLine, convBusy, powerDown, ack;
   logic [7:0] rx;
   tsac_pkg::tsac_od_s sdaPin, alertPin;
   int errCount = 0;
   int compares = 0;
   int n;
   // Clock and pulled-up data wire
   always #25 mclk = ~mclk;
   assign sdaLine = ~(hostLow | sdaPin.oe);
   tsac_core #(.PeriodCyc(Per), .WakeCyc(Wake), .ConvCyc(Conv)) DUT (
      .mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .sclIn(scl), .sdaIn(sdaLine),
      .sdaPin(sdaPin), .alertPin(alertPin), .sensorCode(sensorCode),
      .convBusy(convBusy), .powerDown(powerDown));
   tsac_host host (.scl(scl), .sdaLow(hostLow), .sda(sdaLine));
   // Verdict in one place
   task automatic results();
      $display("compares %0d errors %0d", compares, errCount);
      if (errCount == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Register cycles; read data is taken in its one valid cycle
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge mclk);
      regAddr <= a;
      regWrData <= v;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a);
      @(posedge mclk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      #1 d = regRdData;
   endtask
   // Bounded wait on the busy level, counting cycles
   task automatic waitBusy(input logic lvl);
      n = 0;
      while (convBusy !== lvl) begin
         @(posedge mclk);
         n++;
         if (n > 3000) begin
            errCount++;
            results();
         end
      end
   endtask
   task automatic resetVals();
      rd(3'h1);
      `CHK("cfg", 16'h0040, d)
      rd(3'h2);
      `CHK("upper", 16'h007f, d)
      rd(3'h3);
      `CHK("lower", 16'h0080, d)
      rd(3'h5);
      `CHK("window", 16'h0000, d)
      rd(3'h6);
      `CHK("unmapped", 16'h0000, d)
      wr(3'h4, 8'h02);
      rd(3'h4);
      `CHK("pointer", 16'h0002, d)
      rd(3'h5);
      `CHK("window upper", 16'h007f, d)
      wr(3'h4, 8'h00);
   endtask
   task automatic alertSet();
      wr(3'h2, 8'h10);
      sensorCode <= 10'h080;
      rd(3'h2);
      `CHK("upper wr", 16'h0010, d)
      wr(3'h1, 8'h44);
      waitBusy(1'b1);
      `CHK("oneshot", 1'b1, n < 4)
      waitBusy(1'b0);
      repeat (4) @(posedge mclk);
      `CHK("alert set", 1'b1, alertPin.oe)
      `CHK("od out", 1'b0, alertPin.out)
      rd(3'h0);
      `CHK("temp", 16'h2030, d)
      wr(3'h1, 8'h60);
      repeat (3) @(posedge mclk);
      `CHK("disabled", 1'b0, alertPin.oe)
      wr(3'h1, 8'h40);
      waitBusy(1'b1);
      `CHK("period", 1'b1, n inside {[Per-Conv-30:Per-Conv+4]})
      waitBusy(1'b0);
   endtask
   task automatic araClear();
      sensorCode <= 10'h020;
      host.araRead(8'hff, ack, rx);
      `CHK("ara ack", 1'b1, ack)
      `CHK("ara addr", {tsac_pkg::SLAVE_ADDR, 1'b1}, rx)
      // A lower address pulls low where ours releases, so ours backs off
      host.araRead(8'h81, ack, rx);
      `CHK("ara lost", 8'h81, rx)
      wr(3'h1, 8'h4c);
      waitBusy(1'b1);
      waitBusy(1'b0);
      repeat (4) @(posedge mclk);
      `CHK("alert clear", 1'b0, alertPin.oe)
      host.araRead(8'hff, ack, rx);
      `CHK("ara nack", 1'b0, ack)
      wr(3'h1, 8'h50);
      repeat (3) @(posedge mclk);
      `CHK("pol high", 1'b1, alertPin.oe)
      wr(3'h1, 8'h40);
   endtask
   // Conversion ends inside a link frame, so its result is dropped
   task automatic discard();
      sensorCode <= 10'h0c0;
      wr(3'h1, 8'h44);
      host.araRead(8'hff, ack, rx);
      rd(3'h0);
      `CHK("discarded", 10'h020, d[15:6])
      `CHK("no alert", 1'b0, alertPin.oe)
   endtask
   task automatic sleepShot();
      wr(3'h1, 8'h44);
      waitBusy(1'b1);
      waitBusy(1'b0);
      repeat (4) @(posedge mclk);
      `CHK("alert again", 1'b1, alertPin.oe)
      wr(3'h3, 8'h0c);
      sensorCode <= 10'h010;
      wr(3'h1, 8'hc0);
      repeat (3) @(posedge mclk);
      `CHK("asleep", 1'b1, powerDown)
      wr(3'h1, 8'hc4);
      waitBusy(1'b1);
      waitBusy(1'b0);
      `CHK("wake conv", 1'b1, n inside {[Wake+Conv-3:Wake+Conv+3]})
      repeat (4) @(posedge mclk);
      `CHK("asleep again", 1'b1, powerDown)
      `CHK("low clear", 1'b0, alertPin.oe)
      rd(3'h0);
      `CHK("temp asleep", 10'h010, d[15:6])
      `CHK("flags", 3'b111, d[5:3])
      // Only the lower flag still holds, so only it sets again
      rd(3'h0);
      `CHK("flags again", 3'b001, d[5:3])
      n = 0;
      // Counted per cycle so that an unknown level counts as busy
      repeat (2100) begin
         @(posedge mclk);
         if (convBusy !== 1'b0) n++;
      end
      `CHK("stay asleep", 0, n)
   endtask
   // Main sequence: reset for 8 cycles, then each scenario in turn
   initial begin
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      resetVals();
      alertSet();
      araClear();
      discard();
      sleepShot();
      results();
   end
endmodule
